//--- mhsp_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MHSP_REGS_SVH
`define MHSP_REGS_SVH
// Register offsets on the software port
`define MHSP_CTRL_OFS   3'h0
`define MHSP_TXD_OFS    3'h1
`define MHSP_RXD_OFS    3'h2
`define MHSP_STAT_OFS   3'h3
`define MHSP_MODEM_OFS  3'h4
// Control register fields
`define MHSP_DIV_MSB    15
`define MHSP_LEN_LSB    16
`define MHSP_STOP2_BIT  18
`define MHSP_PAR_LSB    19
// Control reset: divisor 869, 8 data bits, 1 stop, no parity
`define MHSP_CTRL_RST   32'h0003_0365
// Modem control register fields
`define MHSP_DCD_BIT    0
`define MHSP_RI_BIT     1
`define MHSP_SMS_BIT    2
// Status register fields
`define MHSP_ST_TXFULL  0
`define MHSP_ST_TXEMPTY 1
`define MHSP_ST_RXEMPTY 2
`define MHSP_ST_RXFULL  3
`define MHSP_ST_ERR_LSB 4
`define MHSP_ST_DTR     7
`define MHSP_ST_RTS     8
`define MHSP_ST_BUSY    9
// Timing: clock rate and bit-rate ceiling
`define MHSP_CLK_HZ     100000000
`define MHSP_MAX_BPS    115200
// Least divisor, rounded up so the rate never exceeds the ceiling
`define MHSP_MIN_DIV ((`MHSP_CLK_HZ + `MHSP_MAX_BPS - 1) / `MHSP_MAX_BPS)
// Queue depth and clear-to-send headroom
`define MHSP_FIFO_DEPTH 64
`define MHSP_CTS_MARGIN 2
`endif

//--- mhsp_pkg.sv
// Types shared by the host serial port design
package mhsp_pkg;
    // Transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_LOAD  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b011,
        TX_PAR   = 3'b100,
        TX_STOP  = 3'b101
    } mhsp_tx_state_t;
    // Receive sequencer states
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } mhsp_rx_state_t;
    // Parity selection
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD  = 2'b01,
        PAR_EVEN = 2'b10
    } mhsp_parity_t;
endpackage : mhsp_pkg

//--- mhsp_fifo_ram.sv
// Queue storage with registered read data
`timescale 1ns/1ps
module mhsp_fifo_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed

    // Write port
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Read every cycle; a same-cycle write shows one cycle later
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_data_o <= '0;
        end
        else
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule : mhsp_fifo_ram

//--- mhsp_serial_port.sv
// Host-facing serial port with queues and modem control lines
`timescale 1ns/1ps
`include "mhsp_regs.svh"
// Overview of operation
// - Control lines active low, data active high
// - 64-byte transmit and receive queues
// - Data length and stop bits configurable
// - Odd, even or no parity both ways
// - Bit rate capped at 115.2 kbit/s
// - Hardware flow control on send lines
// - Carrier detect low while network connected
// - Ring indicate low on incoming call
// - Modem sends characters on serial output
// - Short-message indicator low on message event
// - Busy low while moving data, idle otherwise
module mhsp_serial_port #(
    parameter int DEPTH = `MHSP_FIFO_DEPTH
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    input  wire logic        serial_in_from_host_i,
    input  wire logic        host_request_send_n_i,
    input  wire logic        terminal_ready_n_i,
    output logic             serial_out_to_host_o,
    output logic             modem_clear_send_n_o,
    output logic             carrier_detect_n_o,
    output logic             ring_indicate_n_o,
    output logic             short_message_led_n_o,
    output logic             busy_led_n_o,
    output logic             idle_led_n_o
);
    import mhsp_pkg::*;

    localparam int          AW      = $clog2(DEPTH);
    localparam logic [15:0] MIN_DIV = 16'(`MHSP_MIN_DIV);
    localparam logic [AW:0] FULL    = (AW+1)'(DEPTH);
    localparam logic [AW:0] CTS_LVL = (AW+1)'(DEPTH - `MHSP_CTS_MARGIN);

    // Configuration and software-visible state
    logic [15:0]    divisor, next_divisor;      // Clocks per bit
    logic [1:0]     len_sel, next_len_sel;      // 0..3 = 5..8 bits
    logic           stop2, next_stop2;          // Two stop bits
    mhsp_parity_t   par_sel, next_par_sel;      // Parity mode
    logic [2:0]     modem_ctl, next_modem_ctl;  // Carrier, ring, sms
    logic [2:0]     err, next_err;              // Parity, frame, overrun
    logic [31:0]    next_rd_data;               // Read answer
    logic           next_cts_n, next_busy_n;    // Registered line drives

    // Queue pointers, one extra bit for full versus empty
    logic [AW:0]    tx_wptr, tx_rptr, rx_wptr, rx_rptr;
    logic [AW:0]    next_tx_rptr, next_rx_rptr;
    logic [AW:0]    tx_fill, rx_fill;
    logic           tx_push, tx_pop, rx_push, rx_pop;
    logic [7:0]     tx_q, rx_q;                 // Queue read data

    // Transmit sequencer
    mhsp_tx_state_t tx_state, next_tx_state;
    logic [15:0]    tx_tick, next_tx_tick;
    logic [2:0]     tx_bit, next_tx_bit;
    logic [7:0]     tx_shift, next_tx_shift;
    logic           tx_par, next_tx_par;
    logic           next_txd;

    // Receive sequencer
    mhsp_rx_state_t rx_state, next_rx_state;
    logic [15:0]    rx_tick, next_rx_tick;
    logic [2:0]     rx_bit, next_rx_bit;
    logic [7:0]     rx_shift, next_rx_shift;
    logic           rx_perr, next_rx_perr;
    logic [2:0]     err_set;                    // Error events

    // Derived character format
    logic [2:0]     last_bit;                   // Index of last data bit
    logic [7:0]     len_mask;                   // Valid data bits
    logic [7:0]     rx_byte;                    // Received, right aligned
    logic           tx_bit_end, rx_bit_end;
    logic           busy;

    assign last_bit   = 3'(len_sel) + 3'd4;
    assign len_mask   = 8'hff >> (3'd7 - last_bit);
    assign rx_byte    = rx_shift >> (3'd7 - last_bit);
    assign tx_fill    = tx_wptr - tx_rptr;
    assign rx_fill    = rx_wptr - rx_rptr;
    assign tx_bit_end = (tx_tick == divisor - 16'h0001);
    assign rx_bit_end = (rx_tick == divisor - 16'h0001);
    assign busy       = (tx_state != TX_IDLE) || (rx_state != RX_IDLE);

    mhsp_fifo_ram #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_ram (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (tx_push),
        .wr_addr_i (tx_wptr[AW-1:0]),
        .wr_data_i (wr_data_i[7:0]),
        .rd_addr_i (next_tx_rptr[AW-1:0]),
        .rd_data_o (tx_q)
    );

    mhsp_fifo_ram #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_ram (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (rx_push),
        .wr_addr_i (rx_wptr[AW-1:0]),
        .wr_data_i (rx_byte),
        .rd_addr_i (next_rx_rptr[AW-1:0]),
        .rd_data_o (rx_q)
    );

    // Software port: decode, writes, queue pops, read answer
    always_comb
    begin
        next_divisor   = divisor;
        next_len_sel   = len_sel;
        next_stop2     = stop2;
        next_par_sel   = par_sel;
        next_modem_ctl = modem_ctl;
        next_rd_data   = 32'h0000_0000;
        tx_push        = 1'b0;
        rx_pop         = 1'b0;
        // Errors clear by writing ones; a new event wins
        next_err       = err | err_set;
        if (wr_i)
        begin
            case (addr_i)
                `MHSP_CTRL_OFS:
                begin
                    next_divisor = (wr_data_i[`MHSP_DIV_MSB:0] < MIN_DIV)
                                 ? MIN_DIV : wr_data_i[`MHSP_DIV_MSB:0];
                    next_len_sel = wr_data_i[`MHSP_LEN_LSB +: 2];
                    next_stop2   = wr_data_i[`MHSP_STOP2_BIT];
                    // parity mode, reserved code means none
                    next_par_sel = (wr_data_i[`MHSP_PAR_LSB +: 2] == 2'b11)
                        ? PAR_NONE
                        : mhsp_parity_t'(wr_data_i[`MHSP_PAR_LSB +: 2]);
                end
                `MHSP_TXD_OFS:   tx_push = (tx_fill != FULL);
                `MHSP_STAT_OFS:
                    next_err = (err & ~wr_data_i[`MHSP_ST_ERR_LSB +: 3])
                             | err_set;
                `MHSP_MODEM_OFS: next_modem_ctl = wr_data_i[2:0];
                default:         next_err = err | err_set;
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                `MHSP_CTRL_OFS:
                    next_rd_data = {11'h000, par_sel, stop2, len_sel,
                                    divisor};
                `MHSP_RXD_OFS:
                begin
                    // Empty queue reads as zero and pops nothing
                    rx_pop       = (rx_fill != '0);
                    next_rd_data = rx_pop ? {24'h000000, rx_q} : 32'h0;
                end
                `MHSP_STAT_OFS:
                begin
                    next_rd_data[`MHSP_ST_TXFULL]  = (tx_fill == FULL);
                    next_rd_data[`MHSP_ST_TXEMPTY] = (tx_fill == '0);
                    next_rd_data[`MHSP_ST_RXEMPTY] = (rx_fill == '0);
                    next_rd_data[`MHSP_ST_RXFULL]  = (rx_fill == FULL);
                    next_rd_data[`MHSP_ST_ERR_LSB +: 3] = err;
                    next_rd_data[`MHSP_ST_DTR]  = !terminal_ready_n_i;
                    next_rd_data[`MHSP_ST_RTS]  = !host_request_send_n_i;
                    next_rd_data[`MHSP_ST_BUSY] = busy;
                end
                `MHSP_MODEM_OFS: next_rd_data = {29'h0, modem_ctl};
                default:         next_rd_data = 32'h0000_0000;
            endcase
        end
        next_tx_rptr = tx_rptr + (AW+1)'(tx_pop);
        next_rx_rptr = rx_rptr + (AW+1)'(rx_pop);
        // hold clear-to-send off near a full queue
        next_cts_n   = (rx_fill >= CTS_LVL);
        next_busy_n  = !busy;
    end

    // Transmit sequencer: load, start, data, parity, stop
    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_tick  = tx_tick + 16'h0001;
        next_tx_bit   = tx_bit;
        next_tx_shift = tx_shift;
        next_tx_par   = tx_par;
        next_txd      = serial_out_to_host_o;
        tx_pop        = 1'b0;
        case (tx_state)
            TX_IDLE:
            begin
                next_txd     = 1'b1;
                next_tx_tick = 16'h0000;
                // start a character only while host request is low
                if ((tx_fill != '0) && !host_request_send_n_i)
                begin
                    next_tx_state = TX_LOAD;
                end
            end
            TX_LOAD:
            begin
                // parity over the valid data bits
                next_tx_par   = ^(tx_q & len_mask) ^ (par_sel == PAR_ODD);
                next_tx_shift = tx_q;
                tx_pop        = 1'b1;
                next_tx_tick  = 16'h0000;
                next_txd      = 1'b0;
                next_tx_state = TX_START;
            end
            TX_START:
            begin
                if (tx_bit_end)
                begin
                    next_tx_tick  = 16'h0000;
                    next_tx_bit   = 3'd0;
                    next_txd      = tx_shift[0];
                    next_tx_state = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (tx_bit_end)
                begin
                    next_tx_tick = 16'h0000;
                    if (tx_bit != last_bit)
                    begin
                        next_tx_bit   = tx_bit + 3'd1;
                        next_tx_shift = tx_shift >> 1;
                        next_txd      = tx_shift[1];
                    end
                    else if (par_sel != PAR_NONE)
                    begin
                        next_txd      = tx_par;
                        next_tx_state = TX_PAR;
                    end
                    else
                    begin
                        next_txd      = 1'b1;
                        next_tx_bit   = 3'd0;
                        next_tx_state = TX_STOP;
                    end
                end
            end
            TX_PAR:
            begin
                if (tx_bit_end)
                begin
                    next_tx_tick  = 16'h0000;
                    next_txd      = 1'b1;
                    next_tx_bit   = 3'd0;
                    next_tx_state = TX_STOP;
                end
            end
            TX_STOP:
            begin
                if (tx_bit_end)
                begin
                    next_tx_tick = 16'h0000;
                    next_tx_bit  = 3'd1;
                    if (!stop2 || (tx_bit == 3'd1))
                    begin
                        next_tx_state = TX_IDLE;
                    end
                end
            end
            default:
            begin
                next_txd      = 1'b1;
                next_tx_state = TX_IDLE;
            end
        endcase
    end

    // Receive sequencer: centre-samples each bit from the start edge
    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_tick  = rx_tick + 16'h0001;
        next_rx_bit   = rx_bit;
        next_rx_shift = rx_shift;
        next_rx_perr  = rx_perr;
        err_set       = 3'b000;
        rx_push       = 1'b0;
        case (rx_state)
            RX_IDLE:
            begin
                next_rx_tick = 16'h0000;
                if (!serial_in_from_host_i)
                begin
                    next_rx_state = RX_START;
                end
            end
            RX_START:
            begin
                // Half a bit in; a high line was only a glitch
                if (rx_tick == (divisor >> 1))
                begin
                    next_rx_tick  = 16'h0000;
                    next_rx_bit   = 3'd0;
                    next_rx_shift = 8'h00;
                    next_rx_perr  = 1'b0;
                    next_rx_state = serial_in_from_host_i ? RX_IDLE
                                                          : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (rx_bit_end)
                begin
                    // first bit lands lowest after alignment
                    next_rx_tick  = 16'h0000;
                    next_rx_shift = {serial_in_from_host_i, rx_shift[7:1]};
                    next_rx_bit   = rx_bit + 3'd1;
                    if (rx_bit == last_bit)
                    begin
                        next_rx_state = (par_sel != PAR_NONE) ? RX_PAR
                                                              : RX_STOP;
                    end
                end
            end
            RX_PAR:
            begin
                if (rx_bit_end)
                begin
                    next_rx_tick  = 16'h0000;
                    next_rx_perr  = serial_in_from_host_i
                                  != (^rx_shift ^ (par_sel == PAR_ODD));
                    next_rx_state = RX_STOP;
                end
            end
            RX_STOP:
            begin
                // First stop bit checked; leave at its centre to resync
                if (rx_bit_end)
                begin
                    err_set[0]    = rx_perr;
                    err_set[1]    = !serial_in_from_host_i;
                    rx_push       = (rx_fill != FULL);
                    err_set[2]    = !rx_push;
                    next_rx_state = RX_IDLE;
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
    end

    // Register all state and output drives
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            divisor               <= 16'(`MHSP_CTRL_RST);
            len_sel               <= 2'(`MHSP_CTRL_RST >> `MHSP_LEN_LSB);
            stop2                 <= 1'b0;
            par_sel               <= PAR_NONE;
            modem_ctl             <= 3'b000;
            err                   <= 3'b000;
            rd_data_o             <= 32'h0000_0000;
            tx_wptr               <= '0;
            tx_rptr               <= '0;
            rx_wptr               <= '0;
            rx_rptr               <= '0;
            tx_state              <= TX_IDLE;
            tx_tick               <= 16'h0000;
            tx_bit                <= 3'd0;
            tx_shift              <= 8'h00;
            tx_par                <= 1'b0;
            rx_state              <= RX_IDLE;
            rx_tick               <= 16'h0000;
            rx_bit                <= 3'd0;
            rx_shift              <= 8'h00;
            rx_perr               <= 1'b0;
            serial_out_to_host_o  <= 1'b1;
            modem_clear_send_n_o  <= 1'b1;
            carrier_detect_n_o    <= 1'b1;
            ring_indicate_n_o     <= 1'b1;
            short_message_led_n_o <= 1'b1;
            busy_led_n_o          <= 1'b1;
            idle_led_n_o          <= 1'b1;
        end
        else
        begin
            divisor               <= next_divisor;
            len_sel               <= next_len_sel;
            stop2                 <= next_stop2;
            par_sel               <= next_par_sel;
            modem_ctl             <= next_modem_ctl;
            err                   <= next_err;
            rd_data_o             <= next_rd_data;
            tx_wptr               <= tx_wptr + (AW+1)'(tx_push);
            tx_rptr               <= next_tx_rptr;
            rx_wptr               <= rx_wptr + (AW+1)'(rx_push);
            rx_rptr               <= next_rx_rptr;
            tx_state              <= next_tx_state;
            tx_tick               <= next_tx_tick;
            tx_bit                <= next_tx_bit;
            tx_shift              <= next_tx_shift;
            tx_par                <= next_tx_par;
            rx_state              <= next_rx_state;
            rx_tick               <= next_rx_tick;
            rx_bit                <= next_rx_bit;
            rx_shift              <= next_rx_shift;
            rx_perr               <= next_rx_perr;
            serial_out_to_host_o  <= next_txd;
            modem_clear_send_n_o  <= next_cts_n;
            carrier_detect_n_o    <= !modem_ctl[`MHSP_DCD_BIT];
            ring_indicate_n_o     <= !modem_ctl[`MHSP_RI_BIT];
            short_message_led_n_o <= !modem_ctl[`MHSP_SMS_BIT];
            busy_led_n_o          <= next_busy_n;
            // idle indicator low when not busy
            idle_led_n_o          <= !next_busy_n;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence load_s;
        tx_state == TX_LOAD;
    endsequence
    sequence start_s;
        (tx_state == TX_START) && !serial_out_to_host_o;
    endsequence

    load_start_a: assert property (load_s |=> start_s)
        else $error("start bit not low after load");
    stop_high_a: assert property (
        (tx_state == TX_STOP) |-> serial_out_to_host_o)
        else $error("stop bit not high");
    cts_pause_a: assert property (
        (tx_state == TX_IDLE && host_request_send_n_i) |=>
        tx_state == TX_IDLE)
        else $error("sent while host request high");
    rate_floor_a: assert property (divisor >= MIN_DIV)
        else $error("bit rate above ceiling");
    queue_bound_a: assert property (
        tx_fill <= FULL && rx_fill <= FULL)
        else $error("queue fill beyond depth");
    carrier_line_a: assert property (
        ##1 carrier_detect_n_o == !$past(modem_ctl[`MHSP_DCD_BIT]))
        else $error("carrier detect wrong level");
    ring_line_a: assert property (
        $rose(modem_ctl[`MHSP_RI_BIT]) |=> !ring_indicate_n_o)
        else $error("ring indicate not low");
    sms_line_a: assert property (
        modem_ctl[`MHSP_SMS_BIT] |=> !short_message_led_n_o)
        else $error("message indicator not low");
    busy_led_a: assert property (
        (tx_state == TX_DATA) |=> !busy_led_n_o ##0 idle_led_n_o)
        else $error("busy indicator wrong while sending");
    parity_out_a: assert property (
        (tx_state == TX_PAR) |-> par_sel != PAR_NONE)
        else $error("parity bit sent with parity off");
endmodule : mhsp_serial_port

//--- mhsp_host_model.sv
// Host terminal model on the serial link
`timescale 1ns/1ps
module mhsp_host_model #(
    parameter int DIV = 869
) (
    input  wire logic       clk_sys_i,
    input  wire logic       line_i,
    output logic            line_o,
    output logic [8:0]      word_o,
    output logic            got_o
);
    logic [8:0] w;
    initial
    begin
        line_o = 1'b1;
        got_o  = 1'b0;
        word_o = 9'h000;
    end
    // sample mid bit, stop kept as bit 8
    always
    begin
        @(negedge line_i);
        repeat (DIV / 2) @(posedge clk_sys_i);
        for (int k = 0; k < 9; k++)
        begin
            repeat (DIV) @(posedge clk_sys_i);
            w[k] = line_i;
        end
        word_o <= w;
        got_o  <= 1'b1;
        @(posedge clk_sys_i);
        got_o  <= 1'b0;
    end
    // low start, bits LSB first, high stop
    task automatic send(input logic [8:0] b, input int n);
        @(posedge clk_sys_i);
        line_o <= 1'b0;
        repeat (DIV) @(posedge clk_sys_i);
        for (int k = 0; k <= n; k++)
        begin
            line_o <= (k == n) ? 1'b1 : b[k];
            repeat (DIV) @(posedge clk_sys_i);
        end
    endtask : send
endmodule : mhsp_host_model

//--- testbench.sv
// Self-checking bench for the host serial port
`timescale 1ns/1ps
module testbench;
    localparam int D = 869;
    logic clk_sys_i, rst_b_i, wr_i, rd_i, rts_n, dtr_n, pend, sin, sout, got;
    logic cts_n, dcd_n, ri_n, sms_n, busy_n, idle_n;
    logic [2:0]  addr_i;
    logic [31:0] wr_data_i, rd_data_o, lfsr;
    logic [8:0]  hw, c;
    logic [31:0] exp_rd[$];
    logic [8:0]  exp_tx[$];
    int n_fail = 0, comparisons = 0;
    mhsp_serial_port DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .serial_in_from_host_i(sin),
        .host_request_send_n_i(rts_n), .terminal_ready_n_i(dtr_n),
        .serial_out_to_host_o(sout), .modem_clear_send_n_o(cts_n),
        .carrier_detect_n_o(dcd_n), .ring_indicate_n_o(ri_n),
        .short_message_led_n_o(sms_n), .busy_led_n_o(busy_n),
        .idle_led_n_o(idle_n));
    mhsp_host_model #(.DIV(D)) host (.clk_sys_i(clk_sys_i), .line_i(sout),
        .line_o(sin), .word_o(hw), .got_o(got));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= w;
        rd_i      <= !w;
        if (!w) exp_rd.push_back(d);
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask : bus
    // Watcher: read answers and decoded characters against notes
    always @(posedge clk_sys_i)
    begin
        if (pend) chk("rd_data", exp_rd.pop_front(), rd_data_o);
        if (got) chk("tx_char", {23'h0, exp_tx.pop_front()}, {23'h0, hw});
        pend <= rd_i;
    end
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (70000) @(posedge clk_sys_i);
        n_fail++;
        summarize;
    end
    initial
    begin
        {rst_b_i, wr_i, rd_i, addr_i, wr_data_i} = '0;
        {rts_n, dtr_n} = 2'b11;
        lfsr  = 32'h72cf;
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        bus(0, 3'h0, 32'h0003_0365);
        bus(1, 3'h0, 32'h0003_0001);
        bus(0, 3'h0, 32'h0003_0365);
        chk("cts_n", 32'h0, {31'h0, cts_n});
        for (int m = 0; m < 8; m++)
        begin
            bus(1, 3'h4, m);
            bus(0, 3'h4, m);
            chk("modem_n", ~m & 7, {sms_n, ri_n, dcd_n});
        end
        lfsr = nxt(lfsr);
        bus(1, 3'h1, {24'h0, lfsr[7:0]});
        repeat (20) @(posedge clk_sys_i);
        chk("held_line", 32'h1, {31'h0, sout});
        bus(0, 3'h3, 32'h04);
        exp_tx.push_back({1'b1, lfsr[7:0]});
        {rts_n, dtr_n} <= 2'b00;
        repeat (D) @(posedge clk_sys_i);
        chk("busy_idle", 32'h1, {30'h0, busy_n, idle_n});
        repeat (11 * D) @(posedge clk_sys_i);
        chk("idle_n", 32'h0, {31'h0, idle_n});
        // Seven bits, even parity, two stops: host keeps parity as bit 7
        bus(1, 3'h0, 32'h0016_0365);
        bus(0, 3'h0, 32'h0016_0365);
        lfsr = nxt(lfsr);
        bus(1, 3'h1, lfsr);
        exp_tx.push_back({1'b1, ^lfsr[6:0], lfsr[6:0]});
        repeat (D * 21 / 2) @(posedge clk_sys_i);
        chk("stop2_busy", 32'h0, {31'h0, busy_n});
        repeat (2 * D) @(posedge clk_sys_i);
        chk("stop2_idle", 32'h0, {31'h0, idle_n});
        for (int i = 0; i < 3; i++)
        begin
            lfsr = nxt(lfsr);
            bus(1, 3'h0, 32'h0003_0365 | ((i == 0 ? 1 : 2) << 19));
            c = {((i == 0) ? ~^lfsr[7:0] : ^lfsr[7:0]) ^ (i == 2),
                 lfsr[7:0]};
            host.send(c, 9);
            bus(0, 3'h3, 32'h182 | ((i == 2) << 4));
            bus(0, 3'h2, {24'h0, c[7:0]});
            bus(1, 3'h3, 32'h70);
        end
        repeat (3) @(posedge clk_sys_i);
        summarize;
    end
endmodule : testbench
